// >>> design/lcr_pkg.sv
/*
  Package for the logic cluster register control block: register map,
  field positions, reset values, control source codes and carrier types.
  Assumes a single clock domain and the plain register port of the top.
*/
package lcr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CELLS = 16;
  localparam int ROW_CLOCKS = 6;
  localparam int LOCAL_CTL = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SRC_W = 4;
  localparam int CTL_COUNT = 8;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_CELL_SEL = 8'h04;
  localparam logic [7:0] OFS_CELL_MODE = 8'h08;
  localparam logic [7:0] OFS_PACK = 8'h0C;
  localparam logic [7:0] OFS_DSEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Source register: one nibble per control signal, in this order
  localparam int SRC_CLK1 = 0;
  localparam int SRC_CLK2 = 1;
  localparam int SRC_ENA1 = 2;
  localparam int SRC_ENA2 = 3;
  localparam int SRC_ACLR1 = 4;
  localparam int SRC_ACLR2 = 5;
  localparam int SRC_SCLR = 6;
  localparam int SRC_SLOAD = 7;
  // Pack register
  localparam int PACK_FALL1 = 16;
  localparam int PACK_FALL2 = 17;
  // Status register
  localparam int ST_SLOAD_BLOCK = 16;
  localparam int ST_CHIP_CLR = 17;
  localparam int ST_IN_USE = 20;
  localparam int ST_LOCAL_USE = 24;

  // ----------------------------------------------------------------
  // Control source codes: 0..5 row clocks, 8..11 local lines
  // ----------------------------------------------------------------
  localparam logic [3:0] SRC_ROW_LAST = 4'h5;
  localparam logic [3:0] SRC_LOCAL_BASE = 4'h8;
  localparam logic [3:0] SRC_OFF = 4'hF;

  // Cell data group codes
  localparam logic [1:0] DSEL_ROWCOL = 2'h0;
  localparam logic [1:0] DSEL_OWN = 2'h1;
  localparam logic [1:0] DSEL_LEFT = 2'h2;
  localparam logic [1:0] DSEL_RIGHT = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_SRC = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_CELL_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_CELL_MODE = 32'h0000_0000;
  localparam logic [31:0] RST_PACK = 32'h0000_0000;
  localparam logic [31:0] RST_DSEL = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tick1;
    logic tick2;
    logic aclr1;
    logic aclr2;
    logic sclr;
    logic sload;
  } lcr_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lcr_bus_t;

endpackage

// >>> design/lcr_cluster.sv
/*
  Logic cluster register control: builds the cluster-wide control
  signals from row clocks and local lines, and runs the sixteen cell
  registers with chain, preset, clear, load and routing choices.
  Assumes every input is synchronous to clk_i; cluster clocks are
  sampled levels whose chosen edge qualifies a register update.
*/
// The plain strobed port and the register addresses were chosen for this implementation.
// Functional notes
// - each cell register can take the previous cell's register output
// - local routing carries outputs of cells inside this cluster
// - each output reaches own cluster plus left and right neighbours, 48 cells; here cell k takes only cell 15-k locally and bit k of each link
// - local routing fed by row/column, own outputs, left and right links
// - cluster makes two clocks, two enables, two clears, sync clear, sync load
// - at most eight control signals in use at one time
// - sync load is disabled while any cell uses register packing
// - at most four non-global control signals; others come from row clocks
// - sync clear or load acts on all cluster registers at next edge
// - each cluster clock is paired with its own clock enable
// - rising plus falling edge use needs both cluster clock lines
// - enable low stops its cluster clock, registers hold
// - control signals chosen from six row clocks and local lines
// - every register has async clear, two independent clear lines
// - preset made by inverting data and output around the clear
// - a register uses preset or clear behaviour, not both
// - enabled chip-wide clear resets all registers, overriding everything
// - each register has data, clock, enable, clear in every mode
`timescale 1ns/1ps
module lcr_cluster #(
  parameter bit CHIP_CLEAR_EN = 1'b1,
  parameter int CELLS = lcr_pkg::CELLS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [5:0] row_clock_i,
  input wire logic [3:0] ctl_local_i,
  input wire logic chip_wide_clear_n_i,
  input wire logic [15:0] row_col_i,
  input wire logic [15:0] direct_left_i,
  input wire logic [15:0] direct_right_i,
  input wire logic [15:0] load_data_i,
  input wire logic chain_in_i,
  output logic [15:0] cell_q_o,
  output logic [15:0] direct_left_o,
  output logic [15:0] direct_right_o,
  output logic chain_out_o
);

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Picks one row clock or local line; unused codes give off_val
  // Codes six, seven and twelve upward select nothing and read as off
  function automatic logic pick_src(input logic [3:0] code, input logic [5:0] rows,
                                    input logic [3:0] locs, input logic off_val);
    logic res;
    res = off_val;
    if (code <= lcr_pkg::SRC_ROW_LAST) begin
      res = rows[code[2:0]];
    end else if (code[3:2] == lcr_pkg::SRC_LOCAL_BASE[3:2]) begin
      res = locs[code[1:0]];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] src_r, src_nxt;
  logic [31:0] cell_sel_r, cell_sel_nxt;
  logic [31:0] cell_mode_r, cell_mode_nxt;
  logic [31:0] pack_r, pack_nxt;
  logic [31:0] dsel_r, dsel_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] status_w;
  lcr_pkg::lcr_bus_t bus;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Write decode; read data stand for the one cycle after the strobe
  always_comb begin
    src_nxt = src_r;
    cell_sel_nxt = cell_sel_r;
    cell_mode_nxt = cell_mode_r;
    pack_nxt = pack_r;
    dsel_nxt = dsel_r;
    rdata_nxt = 32'h0000_0000;
    if (bus.wr) begin
      if (bus.addr == lcr_pkg::OFS_SRC) begin
        src_nxt = bus.wdata;
      end else if (bus.addr == lcr_pkg::OFS_CELL_SEL) begin
        cell_sel_nxt = bus.wdata;
      end else if (bus.addr == lcr_pkg::OFS_CELL_MODE) begin
        cell_mode_nxt = bus.wdata;
      end else if (bus.addr == lcr_pkg::OFS_PACK) begin
        // Bits above the two falling flags are not kept and read as zero
        pack_nxt = {14'h0, bus.wdata[17:0]};
      end else if (bus.addr == lcr_pkg::OFS_DSEL) begin
        dsel_nxt = bus.wdata;
      end
    end
    if (bus.rd) begin
      if (bus.addr == lcr_pkg::OFS_SRC) begin
        rdata_nxt = src_r;
      end else if (bus.addr == lcr_pkg::OFS_CELL_SEL) begin
        rdata_nxt = cell_sel_r;
      end else if (bus.addr == lcr_pkg::OFS_CELL_MODE) begin
        rdata_nxt = cell_mode_r;
      end else if (bus.addr == lcr_pkg::OFS_PACK) begin
        rdata_nxt = pack_r;
      end else if (bus.addr == lcr_pkg::OFS_DSEL) begin
        rdata_nxt = dsel_r;
      end else if (bus.addr == lcr_pkg::OFS_STATUS) begin
        rdata_nxt = status_w;
      end
    end
  end

  // Configuration state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_r <= lcr_pkg::RST_SRC;
      cell_sel_r <= lcr_pkg::RST_CELL_SEL;
      cell_mode_r <= lcr_pkg::RST_CELL_MODE;
      pack_r <= lcr_pkg::RST_PACK;
      dsel_r <= lcr_pkg::RST_DSEL;
      rdata_r <= 32'h0000_0000;
    end else begin
      src_r <= src_nxt;
      cell_sel_r <= cell_sel_nxt;
      cell_mode_r <= cell_mode_nxt;
      pack_r <= pack_nxt;
      dsel_r <= dsel_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Cluster-wide control generation
  // ----------------------------------------------------------------
  logic [3:0] code [8];
  logic lvl1, lvl2, ena1, ena2;
  logic prev1_r, prev1_nxt, prev2_r, prev2_nxt;
  logic edge1, edge2, sload_raw, sload_block;
  lcr_pkg::lcr_ctl_t ctl;

  // Eight fields only, so no more than eight signals in use
  for (genvar s = 0; s < lcr_pkg::CTL_COUNT; s++) begin : g_code
    assign code[s] = src_r[s*lcr_pkg::SRC_W +: lcr_pkg::SRC_W];
  end

  // Off enables read as enabled, off clocks and clears as idle
  always_comb begin
    lvl1 = pick_src(code[lcr_pkg::SRC_CLK1], row_clock_i, ctl_local_i, 1'b0);
    lvl2 = pick_src(code[lcr_pkg::SRC_CLK2], row_clock_i, ctl_local_i, 1'b0);
    ena1 = pick_src(code[lcr_pkg::SRC_ENA1], row_clock_i, ctl_local_i, 1'b1);
    ena2 = pick_src(code[lcr_pkg::SRC_ENA2], row_clock_i, ctl_local_i, 1'b1);
    prev1_nxt = lvl1;
    prev2_nxt = lvl2;
    // Moving a clock source while old and new levels differ looks like an edge,
    // so software should change sources only while the row lines idle
    // Falling flag per line lets one source drive both edges
    edge1 = pack_r[lcr_pkg::PACK_FALL1] ? (prev1_r & ~lvl1) : (lvl1 & ~prev1_r);
    edge2 = pack_r[lcr_pkg::PACK_FALL2] ? (prev2_r & ~lvl2) : (lvl2 & ~prev2_r);
    sload_raw = pick_src(code[lcr_pkg::SRC_SLOAD], row_clock_i, ctl_local_i, 1'b0);
    sload_block = |pack_r[15:0];
    ctl.tick1 = edge1 & ena1;
    ctl.tick2 = edge2 & ena2;
    ctl.aclr1 = pick_src(code[lcr_pkg::SRC_ACLR1], row_clock_i, ctl_local_i, 1'b0);
    ctl.aclr2 = pick_src(code[lcr_pkg::SRC_ACLR2], row_clock_i, ctl_local_i, 1'b0);
    ctl.sclr = pick_src(code[lcr_pkg::SRC_SCLR], row_clock_i, ctl_local_i, 1'b0);
    ctl.sload = sload_raw & ~sload_block;
  end

  // Previous clock levels for edge detection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev1_r <= 1'b0;
      prev2_r <= 1'b0;
    end else begin
      prev1_r <= prev1_nxt;
      prev2_r <= prev2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Chip-wide clear
  // ----------------------------------------------------------------
  // Enable is a build parameter only, software cannot change it
  logic chip_clr;
  assign chip_clr = CHIP_CLEAR_EN & ~chip_wide_clear_n_i;

  // ----------------------------------------------------------------
  // Cell registers
  // ----------------------------------------------------------------
  logic [CELLS-1:0] store_r, store_nxt;
  logic [CELLS-1:0] q_w, aclr_w;

  for (genvar k = 0; k < CELLS; k++) begin : g_cell
    logic use2, use_clr2, preset, chain, tick, d_raw, d_in;
    logic [1:0] dsel;
    assign use2 = cell_sel_r[k];
    assign use_clr2 = cell_sel_r[16+k];
    assign preset = cell_mode_r[k];
    assign chain = cell_mode_r[16+k];
    assign dsel = dsel_r[2*k +: 2];
    assign tick = use2 ? ctl.tick2 : ctl.tick1;
    assign aclr_w[k] = use_clr2 ? ctl.aclr2 : ctl.aclr1;

    // Local routing choice for the data input
    always_comb begin
      if (dsel == lcr_pkg::DSEL_OWN) begin
        d_raw = q_w[CELLS-1-k];
      end else if (dsel == lcr_pkg::DSEL_LEFT) begin
        d_raw = direct_left_i[k];
      end else if (dsel == lcr_pkg::DSEL_RIGHT) begin
        d_raw = direct_right_i[k];
      end else begin
        d_raw = row_col_i[k];
      end
    end

    // Chain input comes from the adjacent cell's register
    if (k == 0) begin : g_head
      assign d_in = chain ? chain_in_i : d_raw;
    end else begin : g_link
      assign d_in = chain ? q_w[k-1] : d_raw;
    end

    // Priority: chip clear, async clear, then edge with sclr over sload
    always_comb begin
      store_nxt[k] = store_r[k];
      if (chip_clr) begin
        store_nxt[k] = 1'b0;
      end else if (aclr_w[k]) begin
        store_nxt[k] = 1'b0;
      end else if (tick) begin
        if (ctl.sclr) begin
          store_nxt[k] = preset;
        end else if (ctl.sload) begin
          store_nxt[k] = load_data_i[k] ^ preset;
        end else begin
          store_nxt[k] = d_in ^ preset;
        end
      end
    end

    // Cleared store shows as one on a preset cell
    assign q_w[k] = (chip_clr | aclr_w[k]) ? preset : (store_r[k] ^ preset);
  end

  // Cell storage; clear hazards are masked on the output at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      store_r <= '0;
    end else begin
      store_r <= store_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and status
  // ----------------------------------------------------------------
  // One output fans to own and both neighbours: cell k goes out as link bit k and by own routing to cell 15-k only
  assign cell_q_o = q_w;
  assign direct_left_o = q_w;
  assign direct_right_o = q_w;
  assign chain_out_o = q_w[CELLS-1];

  logic [3:0] in_use;
  logic [3:0] local_mask;
  logic [3:0] local_use;

  // Any field not set to off counts as in use, even a code that selects nothing
  // Row clocks are global; only the four local lines count
  always_comb begin
    in_use = 4'h0;
    local_mask = 4'h0;
    for (int s = 0; s < lcr_pkg::CTL_COUNT; s++) begin
      if (code[s] != lcr_pkg::SRC_OFF) begin
        in_use = in_use + 4'h1;
      end
      if (code[s][3:2] == lcr_pkg::SRC_LOCAL_BASE[3:2]) begin
        local_mask[code[s][1:0]] = 1'b1;
      end
    end
    local_use = {3'h0, local_mask[0]} + {3'h0, local_mask[1]}
              + {3'h0, local_mask[2]} + {3'h0, local_mask[3]};
  end

  assign status_w = {4'h0, local_use, in_use, 2'h0, chip_clr, sload_block, q_w};

endmodule

// >>> testbench/lcr_cluster_props.sv
/*
  Port checker for the cluster register control block.
  Assumes one clock, clk_i, and the async active-high reset rst_i.
*/
`timescale 1ns/1ps
module lcr_chk #(
  parameter bit CHIP_CLEAR_EN = 1'b1,
  parameter int CELLS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [5:0] row_clock_i,
  input wire logic [3:0] ctl_local_i,
  input wire logic chip_wide_clear_n_i,
  input wire logic [15:0] cell_q_o,
  input wire logic [15:0] direct_left_o,
  input wire logic [15:0] direct_right_o,
  input wire logic chain_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  sequence s_stat_rd;
    rd_i && addr_i == lcr_pkg::OFS_STATUS;
  endsequence
  // No control line change and chip clear released means no register may move
  sequence s_quiet;
    $stable(row_clock_i) && $stable(ctl_local_i) && chip_wide_clear_n_i;
  endsequence
  a_chain_tail: assert property (chain_out_o == cell_q_o[15])
    else $error("chain output differs from last cell");
  a_link_left: assert property (direct_left_o == cell_q_o)
    else $error("left link differs from cells");
  a_link_right: assert property (direct_right_o == cell_q_o)
    else $error("right link differs from cells");
  a_hold_idle: assert property (s_quiet and !wr_i |=> (s_quiet |-> $stable(cell_q_o)))
    else $error("cell moved without a control edge");
  a_chip_hold: assert property (CHIP_CLEAR_EN && !chip_wide_clear_n_i
    && !$past(chip_wide_clear_n_i) && !$past(wr_i) |-> $stable(cell_q_o))
    else $error("cell moved under chip clear");
  a_status_mirror: assert property (s_stat_rd |=> rdata_o[15:0] == $past(cell_q_o))
    else $error("status does not mirror cells");
  a_count_limit: assert property (s_stat_rd |=> rdata_o[23:20] <= 4'h8)
    else $error("more than eight controls in use");
  a_local_limit: assert property (s_stat_rd |=> rdata_o[27:24] <= 4'h4)
    else $error("more than four local controls");
  a_chip_flag: assert property (s_stat_rd ##0 !chip_wide_clear_n_i
    |=> rdata_o[17] == CHIP_CLEAR_EN)
    else $error("chip clear flag wrong");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule
bind lcr_cluster lcr_chk #(.CHIP_CLEAR_EN(CHIP_CLEAR_EN), .CELLS(CELLS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .row_clock_i(row_clock_i), .ctl_local_i(ctl_local_i),
  .chip_wide_clear_n_i(chip_wide_clear_n_i), .cell_q_o(cell_q_o),
  .direct_left_o(direct_left_o), .direct_right_o(direct_right_o),
  .chain_out_o(chain_out_o));

// >>> testbench/lcr_fabric.sv
/*
  Neighbour cluster model driving the direct links.
  Assumes the bench clock and reset.
*/
`timescale 1ns/1ps
module lcr_fabric (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [15:0] left_o,
  output logic [15:0] right_o
);
  logic [15:0] nb_r;
  logic [15:0] nb_nxt;
  // ----------------------------------------------------------------
  // Neighbour rows
  // ----------------------------------------------------------------
  // Walks every cycle so a stale link value never passes for fresh
  always_comb begin
    nb_nxt = {nb_r[14:0], ~nb_r[15]};
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nb_r <= 16'h1234;
    end else begin
      nb_r <= nb_nxt;
    end
  end
  // Sides differ, so a swapped link shows
  assign left_o = nb_r;
  assign right_o = ~{nb_r[7:0], nb_r[15:8]};
endmodule

// >>> testbench/lcr_cluster_tb.sv
/*
  Self-checking bench for the cluster register control block.
  Assumes the package, the design and the neighbour model.
*/
`timescale 1ns/1ps
module lcr_cluster_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [5:0] row_clock_i = 6'h00;
  logic [3:0] ctl_local_i = 4'h0;
  logic chip_n = 1'b1;
  logic [15:0] rc = 16'h0000;
  logic [15:0] ld = 16'h0000;
  logic chain_in = 1'b0;
  logic [15:0] dl_i, dr_i, cell_q_o, lft, rgt;
  logic [31:0] d;
  int mismatches = 0;
  int n_checks = 0;
  // Chip clear enable fixed at build time
  lcr_cluster #(.CHIP_CLEAR_EN(1'b1)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .row_clock_i(row_clock_i), .ctl_local_i(ctl_local_i), .chip_wide_clear_n_i(chip_n),
    .row_col_i(rc), .direct_left_i(dl_i), .direct_right_i(dr_i), .load_data_i(ld),
    .chain_in_i(chain_in), .cell_q_o(cell_q_o), .direct_left_o(), .direct_right_o(),
    .chain_out_o());
  lcr_fabric nbr (.clk_i(clk_i), .rst_i(rst_i), .left_o(dl_i), .right_o(dr_i));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cq(input logic [15:0] e);
    chk({16'h0000, cell_q_o}, {16'h0000, e});
  endtask
  // One rising edge on a row clock; links captured in the tick cycle
  task automatic pulse(input int b);
    @(posedge clk_i);
    row_clock_i[b] <= 1'b1;
    #1 lft = dl_i;
    rgt = dr_i;
    @(posedge clk_i);
    row_clock_i[b] <= 1'b0;
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(lcr_pkg::OFS_SRC, d);
    chk(d, lcr_pkg::RST_SRC);
    rd(lcr_pkg::OFS_CELL_SEL, d);
    chk(d, lcr_pkg::RST_CELL_SEL);
    rd(lcr_pkg::OFS_CELL_MODE, d);
    chk(d, lcr_pkg::RST_CELL_MODE);
    rd(lcr_pkg::OFS_PACK, d);
    chk(d, lcr_pkg::RST_PACK);
    rd(lcr_pkg::OFS_DSEL, d);
    chk(d, lcr_pkg::RST_DSEL);
    wr(lcr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    rd(lcr_pkg::OFS_STATUS, d);
    chk(d, 32'h0000_0000);
    rd(8'h18, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_clock();
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_FFF0);
    @(posedge clk_i) rc <= 16'hA5C3;
    pulse(0);
    cq(16'hA5C3);
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_F8F0);
    @(posedge clk_i) rc <= 16'h0F0F;
    pulse(0);
    cq(16'hA5C3);
    @(posedge clk_i) ctl_local_i <= 4'h1;
    pulse(0);
    cq(16'h0F0F);
    rd(lcr_pkg::OFS_STATUS, d);
    chk(d, 32'h0120_0F0F);
  endtask
  task automatic t_pair();
    wr(lcr_pkg::OFS_CELL_SEL, 32'h0000_00FF);
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_8F10);
    @(posedge clk_i) ctl_local_i <= 4'h0;
    @(posedge clk_i) rc <= 16'hFFFF;
    pulse(1);
    cq(16'h0F0F);
    pulse(0);
    cq(16'hFF0F);
    @(posedge clk_i) ctl_local_i <= 4'h1;
    pulse(1);
    cq(16'hFFFF);
    // Both lines on one source, second one on the falling edge
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_FF00);
    wr(lcr_pkg::OFS_PACK, 32'h0002_0000);
    @(posedge clk_i) rc <= 16'hAAAA;
    pulse(0);
    cq(16'hAAFF);
    @(posedge clk_i);
    #1 cq(16'hAAAA);
    wr(lcr_pkg::OFS_PACK, 32'h0000_0000);
    wr(lcr_pkg::OFS_CELL_SEL, 32'h0000_0000);
  endtask
  task automatic t_route();
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_FFF0);
    wr(lcr_pkg::OFS_CELL_MODE, 32'hFFFF_0000);
    @(posedge clk_i) chain_in <= 1'b1;
    pulse(0);
    cq(16'h5555);
    @(posedge clk_i) chain_in <= 1'b0;
    pulse(0);
    cq(16'hAAAA);
    wr(lcr_pkg::OFS_CELL_MODE, 32'h0000_0000);
    wr(lcr_pkg::OFS_DSEL, 32'h5555_5555);
    pulse(0);
    cq(16'h5555);
    wr(lcr_pkg::OFS_DSEL, 32'hAAAA_AAAA);
    pulse(0);
    cq(lft);
    wr(lcr_pkg::OFS_DSEL, 32'hFFFF_FFFF);
    pulse(0);
    cq(rgt);
    wr(lcr_pkg::OFS_DSEL, 32'h0000_0000);
  endtask
  // Only two local lines in use, within the non-global limit
  task automatic t_sync();
    wr(lcr_pkg::OFS_SRC, 32'hA9FF_FFF0);
    @(posedge clk_i) ld <= 16'hC3C3;
    @(posedge clk_i) rc <= 16'h1111;
    @(posedge clk_i) ctl_local_i <= 4'h4;
    pulse(0);
    cq(16'hC3C3);
    @(posedge clk_i) ctl_local_i <= 4'h6;
    pulse(0);
    cq(16'h0000);
    rd(lcr_pkg::OFS_STATUS, d);
    chk(d, 32'h0230_0000);
    wr(lcr_pkg::OFS_PACK, 32'h0000_0001);
    @(posedge clk_i) ctl_local_i <= 4'h4;
    pulse(0);
    cq(16'h1111);
    rd(lcr_pkg::OFS_STATUS, d);
    chk(d, 32'h0231_1111);
    wr(lcr_pkg::OFS_PACK, 32'h0000_0000);
    @(posedge clk_i) ctl_local_i <= 4'h0;
  endtask
  // Cell 0 uses preset only, never a plain clear too
  task automatic t_clear();
    wr(lcr_pkg::OFS_SRC, 32'hFF5B_FFF0);
    wr(lcr_pkg::OFS_CELL_SEL, 32'hFF00_0000);
    wr(lcr_pkg::OFS_CELL_MODE, 32'h0000_0001);
    @(posedge clk_i) rc <= 16'hFFFF;
    pulse(0);
    cq(16'hFFFF);
    @(posedge clk_i) ctl_local_i <= 4'h8;
    #1 cq(16'hFF01);
    pulse(0);
    cq(16'hFF01);
    @(posedge clk_i) ctl_local_i <= 4'h0;
    row_clock_i[5] <= 1'b1;
    #1 cq(16'h0001);
    @(posedge clk_i) row_clock_i[5] <= 1'b0;
    wr(lcr_pkg::OFS_CELL_MODE, 32'h0000_0000);
    wr(lcr_pkg::OFS_CELL_SEL, 32'h0000_0000);
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_FFF0);
    pulse(0);
    cq(16'hFFFF);
    @(posedge clk_i) chip_n <= 1'b0;
    #1 cq(16'h0000);
    pulse(0);
    cq(16'h0000);
    rd(lcr_pkg::OFS_STATUS, d);
    chk(d, 32'h0012_0000);
    @(posedge clk_i) chip_n <= 1'b1;
  endtask
  // Clock one on its falling edge only; the rising edge must not load
  task automatic t_fall();
    wr(lcr_pkg::OFS_SRC, 32'hFFFF_FFF0);
    wr(lcr_pkg::OFS_PACK, 32'h0001_0000);
    @(posedge clk_i) rc <= 16'h3C3C;
    pulse(0);
    cq(16'h0000);
    @(posedge clk_i);
    #1 cq(16'h3C3C);
    wr(lcr_pkg::OFS_PACK, 32'h0000_0000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_clock();
    t_pair();
    t_route();
    t_sync();
    t_clear();
    t_fall();
    wrap_up();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
endmodule
